// >>> hdl/asi_core.sv
// full-duplex asynchronous serial interface: registers, baud, receiver, interrupt
// Notes on behaviour
// - transmit and receive run at once, nrz coding, separate lines.
// - bit rate is bus clock divided by sixteen times the divisor.
// - parity generated on transmit, checked on receive, even or odd.
// - eight or nine data bits, same length at both ends.
// - break reported when line stays low eleven or thirteen bit times.
// - one holding buffer each way besides the shifter.
// - dormant receiver woken by idle line or address-marked character.
// - transmit output and receive input polarity each invertible.
// - loop mode routes transmitter internally to receiver.
// - single-wire half duplex, transmit and receive share one pin.
// - data bits go least significant bit first only.
// - every event has a status flag and its own mask bit.
`timescale 1ns/1ps
`include "asi_map.svh"
module asi_core (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // serial pins
  input wire logic rx_i,
  input wire logic line_i,
  output logic line_o,
  output logic line_oe_b_o,
  // interrupt
  output logic irq_o
);
  // software registers
  logic [12:0] baud_reg;
  logic [15:0] ctrl_reg;
  logic [7:0] mask_reg;
  logic [7:0] stat_reg;
  logic [7:0] stat_next;
  logic [15:0] rdata_reg;
  logic irq_reg;
  // pins
  logic rx_s1_reg;
  logic rx_s2_reg;
  logic ln_s1_reg;
  logic ln_s2_reg;
  logic line_reg;
  logic oe_b_reg;
  // baud
  logic [12:0] div_reg;
  logic tick;
  // transmit side
  logic [8:0] tx_buf_reg;
  logic tx_full_reg;
  logic tx_go;
  logic tx_idle;
  logic tx_done;
  logic tx_line;
  // receive side
  asi_pkg::asi_rx_state_e rx_state_reg;
  logic [3:0] rx_cnt_reg;
  logic [3:0] rx_idx_reg;
  logic [9:0] rx_sh_reg;
  logic [8:0] rx_buf_reg;
  logic rx_full_reg;
  logic [7:0] idle_cnt_reg;
  logic idle_arm_reg;
  logic [7:0] brk_cnt_reg;
  logic rx_in;
  logic [3:0] rx_nbits;
  logic [9:0] word;
  logic [8:0] rx_data;
  logic rx_pbit;
  logic rx_done;
  logic rx_take;
  logic perr;
  logic mark;
  logic wake;
  logic idle_ev;
  logic brk_ev;
  logic [7:0] frame_ticks;
  logic [7:0] brk_ticks;
  logic [7:0] ev;
  // decoded accesses
  logic wr_ctrl;
  logic rd_stat;
  logic rd_data;
  logic wr_data;

  // control fields
  logic par_en;
  logic par_odd;
  logic nine;
  logic wake_addr;
  logic loop_mode;
  logic single;
  logic tx_inv;
  logic rx_inv;
  logic brk13;
  logic tx_en;
  logic rx_en;
  logic dormant;
  logic tx_dir;

  assign par_en = ctrl_reg[`ASI_C_PAR_EN];
  assign par_odd = ctrl_reg[`ASI_C_PAR_ODD];
  assign nine = ctrl_reg[`ASI_C_NINE];
  assign wake_addr = ctrl_reg[`ASI_C_WAKE_ADDR];
  assign loop_mode = ctrl_reg[`ASI_C_LOOP];
  assign single = ctrl_reg[`ASI_C_SINGLE];
  assign tx_inv = ctrl_reg[`ASI_C_TX_INV];
  assign rx_inv = ctrl_reg[`ASI_C_RX_INV];
  assign brk13 = ctrl_reg[`ASI_C_BRK13];
  assign tx_en = ctrl_reg[`ASI_C_TX_EN];
  assign rx_en = ctrl_reg[`ASI_C_RX_EN];
  assign dormant = ctrl_reg[`ASI_C_DORMANT];
  assign tx_dir = ctrl_reg[`ASI_C_TX_DIR];

  // access decode
  assign wr_ctrl = wr_i && (addr_i == `ASI_OFS_CTRL);
  assign wr_data = wr_i && (addr_i == `ASI_OFS_DATA);
  assign rd_stat = rd_i && (addr_i == `ASI_OFS_STAT);
  assign rd_data = rd_i && (addr_i == `ASI_OFS_DATA);

  // two-flop synchronisers on both pin inputs
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
      ln_s1_reg <= 1'b1;
      ln_s2_reg <= 1'b1;
    end else begin
      rx_s1_reg <= rx_i;
      rx_s2_reg <= rx_s1_reg;
      ln_s1_reg <= line_i;
      ln_s2_reg <= ln_s1_reg;
    end
  end

  // oversample tick every divisor clocks; divisor zero halts the link
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_reg <= `ASI_BAUD_RST;
    end else if (div_reg <= 13'h0001) begin
      div_reg <= baud_reg;
    end else begin
      div_reg <= div_reg - 13'h0001;
    end
  end
  assign tick = (div_reg <= 13'h0001) && (baud_reg != 13'h0000);

  // baud and mask registers
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      baud_reg <= `ASI_BAUD_RST;
      mask_reg <= `ASI_MASK_RST;
    end else if (wr_i) begin
      if (addr_i == `ASI_OFS_BAUD) begin
        baud_reg <= wdata_i[12:0];
      end
      if (addr_i == `ASI_OFS_MASK) begin
        mask_reg <= wdata_i[7:0];
      end
    end
  end

  // control register; hardware drops the dormant bit on wake-up
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_reg <= `ASI_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= wdata_i;
    end else if (wake) begin
      ctrl_reg[`ASI_C_DORMANT] <= 1'b0;
    end
  end

  // transmit holding buffer; a write while full is dropped
  assign tx_go = tx_full_reg && tx_idle && tx_en;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_buf_reg <= 9'h000;
      tx_full_reg <= 1'b0;
    end else if (wr_data && !tx_full_reg) begin
      tx_buf_reg <= wdata_i[8:0];
      tx_full_reg <= 1'b1;
    end else if (tx_go) begin
      tx_full_reg <= 1'b0;
    end
  end

  asi_tx u_tx (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .tick_i(tick),
    .start_i(tx_go),
    .data_i(tx_buf_reg),
    .nine_i(nine),
    .par_en_i(par_en),
    .par_odd_i(par_odd),
    .idle_o(tx_idle),
    .done_o(tx_done),
    .line_o(tx_line)
  );

  // pin drive: loop keeps the pin at rest, single wire drives only while tx_dir is set
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      line_reg <= 1'b1;
      oe_b_reg <= 1'b0;
    end else begin
      line_reg <= (loop_mode ? 1'b1 : tx_line) ^ tx_inv;
      oe_b_reg <= single && !tx_dir;
    end
  end

  // receive source: internal loop skips the pins and their inversion
  always_comb begin
    if (loop_mode) begin
      rx_in = tx_line;
    end else if (single) begin
      rx_in = ln_s2_reg ^ rx_inv;
    end else begin
      rx_in = rx_s2_reg ^ rx_inv;
    end
  end

  // frame layout of the receiver
  assign rx_nbits = (nine ? 4'h9 : 4'h8) + {3'h0, par_en};
  assign frame_ticks = {rx_nbits + 4'h2, 4'h0};
  assign brk_ticks = {(brk13 ? `ASI_BRK_LONG_BITS : `ASI_BRK_SHORT_BITS), 4'h0};

  // receive state machine, sixteen samples per bit, centre sampling
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_state_reg <= asi_pkg::RX_IDLE;
      rx_cnt_reg <= 4'h0;
      rx_idx_reg <= 4'h0;
      rx_sh_reg <= 10'h000;
    end else if (!rx_en) begin
      rx_state_reg <= asi_pkg::RX_IDLE;
    end else if (tick) begin
      rx_cnt_reg <= rx_cnt_reg + 4'h1;
      unique case (rx_state_reg)
        asi_pkg::RX_IDLE: begin
          rx_cnt_reg <= 4'h0;
          if (!rx_in) begin
            rx_state_reg <= asi_pkg::RX_START;
          end
        end
        asi_pkg::RX_START: begin
          if (rx_cnt_reg == `ASI_MID_SAMPLE) begin
            rx_cnt_reg <= 4'h0;
            rx_idx_reg <= 4'h0;
            // a glitch shorter than half a bit is not a start
            rx_state_reg <= rx_in ? asi_pkg::RX_IDLE : asi_pkg::RX_DATA;
          end
        end
        asi_pkg::RX_DATA: begin
          if (rx_cnt_reg == `ASI_LAST_SAMPLE) begin
            rx_sh_reg <= {rx_in, rx_sh_reg[9:1]};
            rx_idx_reg <= rx_idx_reg + 4'h1;
            if (rx_idx_reg == rx_nbits - 4'h1) begin
              rx_state_reg <= asi_pkg::RX_STOP;
            end
          end
        end
        asi_pkg::RX_STOP: begin
          if (rx_cnt_reg == `ASI_LAST_SAMPLE) begin
            rx_state_reg <= asi_pkg::RX_IDLE;
          end
        end
      endcase
    end
  end

  // frame evaluation at the centre of the stop bit
  always_comb begin
    word = rx_sh_reg >> (4'hA - rx_nbits);
    rx_data = nine ? word[8:0] : {1'b0, word[7:0]};
    rx_pbit = nine ? word[9] : word[8];
    perr = par_en && (^rx_data ^ rx_pbit ^ par_odd);
    mark = nine ? rx_data[8] : rx_data[7];
  end
  assign rx_done = tick && rx_en && (rx_state_reg == asi_pkg::RX_STOP)
                   && (rx_cnt_reg == `ASI_LAST_SAMPLE);
  assign rx_take = rx_done && (!dormant || (wake_addr && mark));
  assign wake = dormant && ((rx_done && wake_addr && mark)
                            || (idle_ev && !wake_addr));

  // receive holding buffer; a full buffer keeps the older character
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_buf_reg <= 9'h000;
      rx_full_reg <= 1'b0;
    end else if (rx_take && !rx_full_reg) begin
      rx_buf_reg <= rx_data;
      rx_full_reg <= 1'b1;
    end else if (rd_data) begin
      rx_full_reg <= 1'b0;
    end
  end

  // idle line: one whole frame time of mark after any low
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      idle_cnt_reg <= 8'h00;
      idle_arm_reg <= 1'b0;
    end else if (tick && rx_en) begin
      if (!rx_in) begin
        idle_cnt_reg <= 8'h00;
        idle_arm_reg <= 1'b1;
      end else if (idle_ev) begin
        idle_arm_reg <= 1'b0;
      end else if (idle_arm_reg) begin
        idle_cnt_reg <= idle_cnt_reg + 8'h01;
      end
    end
  end
  assign idle_ev = tick && rx_en && rx_in && idle_arm_reg
                   && (idle_cnt_reg == frame_ticks - 8'h01);

  // break: counter holds at its limit so one long low flags once
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      brk_cnt_reg <= 8'h00;
    end else if (tick && rx_en) begin
      if (rx_in) begin
        brk_cnt_reg <= 8'h00;
      end else if (brk_cnt_reg != brk_ticks) begin
        brk_cnt_reg <= brk_cnt_reg + 8'h01;
      end
    end
  end
  assign brk_ev = tick && rx_en && !rx_in && (brk_cnt_reg == brk_ticks - 8'h01);

  // events gathered in status layout
  always_comb begin
    ev = 8'h00;
    ev[`ASI_S_TX_EMPTY] = tx_go;
    ev[`ASI_S_TX_DONE] = tx_done && !tx_full_reg;
    ev[`ASI_S_RX_FULL] = rx_take && !rx_full_reg;
    ev[`ASI_S_IDLE] = idle_ev;
    ev[`ASI_S_OVERRUN] = rx_take && rx_full_reg;
    ev[`ASI_S_PARITY] = rx_take && perr;
    ev[`ASI_S_FRAMING] = rx_take && !rx_in;
    ev[`ASI_S_BREAK] = brk_ev;
  end

  // sticky status cleared by its read; a new event in that cycle survives
  always_comb begin
    stat_next = rd_stat ? ev : (stat_reg | ev);
  end
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stat_reg <= 8'h00;
    end else begin
      stat_reg <= stat_next;
    end
  end

  // level interrupt from masked status, polling works with mask zero
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(stat_next & mask_reg);
    end
  end

  // read data valid the cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_reg <= 16'h0000;
    end else if (rd_i) begin
      unique case (addr_i)
        `ASI_OFS_BAUD: rdata_reg <= {3'h0, baud_reg};
        `ASI_OFS_CTRL: rdata_reg <= ctrl_reg;
        `ASI_OFS_STAT: rdata_reg <= {8'h00, stat_reg};
        `ASI_OFS_MASK: rdata_reg <= {8'h00, mask_reg};
        `ASI_OFS_DATA: rdata_reg <= {7'h00, rx_buf_reg};
        `ASI_OFS_LIVE: rdata_reg <= {11'h000, dormant,
                                     rx_state_reg != asi_pkg::RX_IDLE,
                                     !tx_idle, rx_full_reg, !tx_full_reg};
        default: rdata_reg <= 16'h0000;
      endcase
    end else begin
      rdata_reg <= 16'h0000;
    end
  end

  assign rdata_o = rdata_reg;
  assign line_o = line_reg;
  assign line_oe_b_o = oe_b_reg;
  assign irq_o = irq_reg;
endmodule

// >>> hdl/asi_map.svh
// register map, field positions, reset values and timing counts of the serial interface
`ifndef ASI_MAP_SVH
`define ASI_MAP_SVH

// register offsets
`define ASI_OFS_BAUD 8'h00
`define ASI_OFS_CTRL 8'h01
`define ASI_OFS_STAT 8'h02
`define ASI_OFS_MASK 8'h03
`define ASI_OFS_DATA 8'h04
`define ASI_OFS_LIVE 8'h05

// control register fields
`define ASI_C_PAR_EN 0
`define ASI_C_PAR_ODD 1
`define ASI_C_NINE 2
`define ASI_C_WAKE_ADDR 3
`define ASI_C_LOOP 4
`define ASI_C_SINGLE 5
`define ASI_C_TX_INV 6
`define ASI_C_RX_INV 7
`define ASI_C_BRK13 8
`define ASI_C_TX_EN 9
`define ASI_C_RX_EN 10
`define ASI_C_DORMANT 11
`define ASI_C_TX_DIR 12

// status and mask fields
`define ASI_S_TX_EMPTY 0
`define ASI_S_TX_DONE 1
`define ASI_S_RX_FULL 2
`define ASI_S_IDLE 3
`define ASI_S_OVERRUN 4
`define ASI_S_PARITY 5
`define ASI_S_FRAMING 6
`define ASI_S_BREAK 7

// reset values
`define ASI_BAUD_RST 13'h0001
`define ASI_CTRL_RST 16'h0000
`define ASI_MASK_RST 8'h00

// timing counts, in oversample ticks or bit times
`define ASI_MID_SAMPLE 4'h7
`define ASI_LAST_SAMPLE 4'hF
`define ASI_BRK_SHORT_BITS 4'hB
`define ASI_BRK_LONG_BITS 4'hD

`endif

// >>> hdl/asi_pkg.sv
// types shared by the serial interface modules
package asi_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} asi_rx_state_e;
endpackage

// >>> hdl/asi_tx.sv
// transmit shifter of the serial interface
`timescale 1ns/1ps
`include "asi_map.svh"
module asi_tx (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // timing and load
  input wire logic tick_i,
  input wire logic start_i,
  input wire logic [8:0] data_i,
  // format
  input wire logic nine_i,
  input wire logic par_en_i,
  input wire logic par_odd_i,
  // status and line
  output logic idle_o,
  output logic done_o,
  output logic line_o
);
  logic [11:0] sh_reg;
  logic [3:0] sub_reg;
  logic [3:0] bit_reg;
  logic [3:0] nbits_reg;
  logic busy_reg;
  logic done_reg;
  logic par;
  logic pbit;
  logic [10:0] body;

  // parity over the data field, stop bit placed above it
  always_comb begin
    par = (nine_i ? ^data_i : ^data_i[7:0]) ^ par_odd_i;
    pbit = par_en_i ? par : 1'b1;
    body = nine_i ? {1'b1, pbit, data_i} : {2'b11, pbit, data_i[7:0]};
  end

  // shifter idles all ones so the line rests high between frames
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sh_reg <= 12'hFFF;
      sub_reg <= 4'h0;
      bit_reg <= 4'h0;
      nbits_reg <= 4'h0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (start_i && !busy_reg) begin
        sh_reg <= {body, 1'b0};
        nbits_reg <= 4'hA + {3'h0, nine_i} + {3'h0, par_en_i};
        sub_reg <= 4'h0;
        bit_reg <= 4'h0;
        busy_reg <= 1'b1;
      end else if (busy_reg && tick_i) begin
        sub_reg <= sub_reg + 4'h1;
        if (sub_reg == `ASI_LAST_SAMPLE) begin
          sh_reg <= {1'b1, sh_reg[11:1]};
          bit_reg <= bit_reg + 4'h1;
          if (bit_reg == nbits_reg - 4'h1) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
          end
        end
      end
    end
  end

  assign line_o = sh_reg[0];
  assign idle_o = !busy_reg;
  assign done_o = done_reg;
endmodule

// >>> verification/asi_core_sva.sv
// concurrent checks on the serial interface top ports
`timescale 1ns/1ps
`include "asi_map.svh"
module asi_core_sva (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  // pins and interrupt
  input wire logic rx_i,
  input wire logic line_i,
  input wire logic line_o,
  input wire logic line_oe_b_o,
  input wire logic irq_o
);
  logic [15:0] ctrl_reg;
  logic [12:0] baud_reg;
  logic [7:0] mask_reg;
  logic go;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  // shadow of software settings; the hardware clear of dormant is not tracked
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_reg <= `ASI_CTRL_RST;
      baud_reg <= `ASI_BAUD_RST;
      mask_reg <= `ASI_MASK_RST;
    end else if (wr_i) begin
      if (addr_i == `ASI_OFS_CTRL) ctrl_reg <= wdata_i;
      if (addr_i == `ASI_OFS_BAUD) baud_reg <= wdata_i[12:0];
      if (addr_i == `ASI_OFS_MASK) mask_reg <= wdata_i[7:0];
    end
  end
  // bit length is only pinned down at divisor one with a plain transmitter
  assign go = ctrl_reg[`ASI_C_TX_EN] & ~ctrl_reg[`ASI_C_TX_INV] & ~ctrl_reg[`ASI_C_LOOP]
    & (baud_reg == 13'h0001);
  property p_rd_quiet;
    !$past(rd_i) |-> rdata_o == 16'h0000;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside a read");
  property p_unmapped;
    rd_i && addr_i > `ASI_OFS_LIVE |=> rdata_o == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_baud_rb;
    rd_i && addr_i == `ASI_OFS_BAUD |=> rdata_o == {3'h0, baud_reg};
  endproperty
  a_baud_rb: assert property (p_baud_rb) else $error("divisor read back wrong");
  property p_mask_rb;
    rd_i && addr_i == `ASI_OFS_MASK |=> rdata_o == {8'h00, mask_reg};
  endproperty
  a_mask_rb: assert property (p_mask_rb) else $error("mask read back wrong");
  property p_oe;
    $stable(ctrl_reg) |-> line_oe_b_o == (ctrl_reg[`ASI_C_SINGLE] & ~ctrl_reg[`ASI_C_TX_DIR]);
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  property p_no_irq;
    mask_reg == 8'h00 && $past(mask_reg) == 8'h00 |-> !irq_o;
  endproperty
  a_no_irq: assert property (p_no_irq) else $error("interrupt with all masked");
  property p_idle_lvl;
    $stable(ctrl_reg) && !ctrl_reg[`ASI_C_TX_EN] |-> line_o == !ctrl_reg[`ASI_C_TX_INV];
  endproperty
  a_idle_lvl: assert property (p_idle_lvl) else $error("idle level wrong");
  property p_loop_rest;
    $stable(ctrl_reg) && ctrl_reg[`ASI_C_LOOP] |-> line_o == !ctrl_reg[`ASI_C_TX_INV];
  endproperty
  a_loop_rest: assert property (p_loop_rest) else $error("pin moved in loop mode");
  property p_start;
    go && $fell(line_o) |-> ##15 !line_o;
  endproperty
  a_start: assert property (p_start) else $error("start bit too short");
  c_stat_irq: cover property (rd_i && addr_i == `ASI_OFS_STAT && irq_o);
  c_loop: cover property (ctrl_reg[`ASI_C_LOOP] && wr_i && addr_i == `ASI_OFS_DATA);
  c_single: cover property (line_oe_b_o ##1 rd_i);
endmodule

// >>> verification/asi_remote.sv
// behavioural remote serial device on the far side of the pins
`timescale 1ns/1ps
module asi_remote (
  // clock
  input wire logic core_clk_i,
  // line heard and line driven
  input wire logic pin_i,
  output logic ser_o
);
  int rx_bits = 9;
  logic [15:0] got[$];
  logic [15:0] v;
  initial ser_o = 1'b1;
  // low start bit, given bits lsb first, 16 clocks each, then back to idle high
  task automatic send(input logic [15:0] f, input int n);
    for (int i = 0; i <= n + 1; i++) begin
      @(posedge core_clk_i);
      ser_o <= i == 0 ? 1'b0 : i > n ? 1'b1 : f[i - 1];
      if (i <= n) repeat (15) @(posedge core_clk_i);
    end
  endtask
  // sample each bit at its centre, counted from the falling start edge
  always @(negedge pin_i) begin
    v = 16'h0000;
    repeat (8) @(posedge core_clk_i);
    for (int i = 0; i < rx_bits; i++) begin
      repeat (16) @(posedge core_clk_i);
      v[i] = pin_i;
    end
    got.push_back(v);
  end
endmodule

// >>> verification/asi_core_tb_top.sv
// self-checking bench of the serial interface
`timescale 1ns/1ps
`include "asi_map.svh"
module asi_core_tb_top;
  typedef struct {logic [15:0] v; logic [15:0] m;} asi_exp_s;
  logic core_clk_i, rst_b_i, wr_i, rd_i, rd_d, ser, rx, pin, line_i, line_o, line_oe_b_o, irq_o;
  logic [7:0] addr_i;
  logic [15:0] wdata_i, rdata_o, ctl;
  logic [8:0] b;
  logic quiet;
  int fail_count = 0;
  int comparisons = 0;
  asi_exp_s e;
  asi_exp_s rq[$];
  logic [15:0] fq[$];
  // wire levels: the remote hears only what the block drives; line_i echoes the block's own drive while it drives the pin
  assign line_i = line_oe_b_o ? ser : line_o;
  assign rx = line_oe_b_o ? 1'b1 : ser;
  // quiet keeps the remote deaf while the block talks to itself on the wire
  assign pin = (line_oe_b_o | quiet) ? 1'b1 : line_o;
  asi_core i_asi_core (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_i(rx),
    .line_i(line_i), .line_o(line_o), .line_oe_b_o(line_oe_b_o), .irq_o(irq_o));
  asi_remote i_asi_remote (.core_clk_i(core_clk_i), .pin_i(pin), .ser_o(ser));
  task automatic cmp(input string what, input logic [15:0] ex, input logic [15:0] s);
    comparisons++;
    if (s !== ex) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, ex, s);
    end
  endtask
  task automatic report_and_stop;
    if (fail_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] ex, input logic [15:0] m);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    rq.push_back('{ex & m, m});
    @(posedge core_clk_i);
    rd_i <= 1'b0;
  endtask
  task automatic wait_irq(input logic want);
    for (int n = 0; n < 4000 && irq_o !== want; n++) @(posedge core_clk_i);
    cmp("irq", want, irq_o);
  endtask
  // frame body as the line carries it: data, optional parity, stop
  function automatic logic [15:0] frame(input logic [8:0] d, input logic nine, input logic pe,
      input logic odd, input logic bad);
    logic [15:0] f;
    f = {7'h00, d} & (nine ? 16'h01FF : 16'h00FF);
    if (pe) f[8 + nine] = (nine ? ^d : ^d[7:0]) ^ odd ^ bad;
    f[8 + nine + pe] = 1'b1;
    return f;
  endfunction
  task automatic rx_char(input logic [8:0] d, input logic [15:0] c, input logic bad);
    i_asi_remote.send(frame(d, c[2], c[0], c[1], bad), 9 + c[2] + c[0]);
  endtask
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  // second process: pair each answer with the oldest note
  always @(posedge core_clk_i) begin
    rd_d <= rd_i;
    if (rd_d === 1'b1) begin
      e = rq.pop_front();
      cmp("read data", e.v, rdata_o & e.m);
    end
    if (i_asi_remote.got.size() > 0) cmp("frame", fq.pop_front(), i_asi_remote.got.pop_front());
  end
  // watchdog well beyond the roughly 8000 cycles the tests need
  initial begin
    repeat (60000) @(posedge core_clk_i);
    fail_count++;
    report_and_stop();
  end
  initial begin
    rst_b_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    rd_d = 1'b0;
    quiet = 1'b0;
    addr_i = 8'h00;
    wdata_i = 16'h0000;
    void'($urandom(2707));
    repeat (12) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    cmp("pins", 16'h0001, {line_oe_b_o, line_o});
    wr(8'h3C, 16'hFFFF);
    rd(`ASI_OFS_BAUD, `ASI_BAUD_RST, 16'hFFFF);
    rd(`ASI_OFS_CTRL, `ASI_CTRL_RST, 16'hFFFF);
    rd(`ASI_OFS_MASK, `ASI_MASK_RST, 16'hFFFF);
    rd(`ASI_OFS_STAT, 16'h0000, 16'hFFFF);
    rd(8'h3C, 16'h0000, 16'hFFFF);
    rd(`ASI_OFS_LIVE, 16'h0001, 16'hFFFF);
    wr(`ASI_OFS_BAUD, 16'h0001);
    wr(`ASI_OFS_MASK, 16'h0004);
    // every format: parity off, even, odd; eight or nine bits; good then, where parity is on, bad parity
    for (int i = 0; i < 8; i++) begin
      ctl = {13'h00C0, i[2:0]};
      wr(`ASI_OFS_CTRL, ctl);
      for (int j = 0; j < 2; j++) begin
        b = 9'($urandom);
        rx_char(b, ctl, j[0] & ctl[0]);
        wait_irq(1'b1);
        rd(`ASI_OFS_STAT, {10'h000, j[0] & ctl[0], 5'h04}, 16'h0074);
        rd(`ASI_OFS_DATA, ctl[2] ? b : b & 9'h0FF, 16'h01FF);
        wait_irq(1'b0);
      end
    end
    wr(`ASI_OFS_MASK, 16'h0000);
    wr(`ASI_OFS_CTRL, 16'h0600);
    rx_char(9'h0A5, 16'h0600, 1'b0);
    rx_char(9'h05A, 16'h0600, 1'b0);
    cmp("irq", 16'h0000, irq_o);
    rd(`ASI_OFS_STAT, 16'h0014, 16'h0074);
    rd(`ASI_OFS_DATA, 16'h00A5, 16'h01FF);
    wr(`ASI_OFS_MASK, 16'h0080);
    // line held low 12, 12 and 14 bit times against the 11 and 13 bit thresholds
    for (int i = 0; i < 3; i++) begin
      wr(`ASI_OFS_CTRL, i > 0 ? 16'h0700 : 16'h0600);
      i_asi_remote.send(16'h0000, i < 2 ? 11 : 13);
      repeat (160) @(posedge core_clk_i);
      rd(`ASI_OFS_STAT, i == 1 ? 16'h0040 : 16'h00C0, 16'h00C0);
      rd(`ASI_OFS_DATA, 16'h0000, 16'h0000);
    end
    // dormant: idle wake first, address-mark wake second; the first char is dropped
    for (int i = 0; i < 2; i++) begin
      repeat (200) @(posedge core_clk_i);
      wr(`ASI_OFS_CTRL, i > 0 ? 16'h0E08 : 16'h0E00);
      rx_char(9'h012, 16'h0600, 1'b0);
      repeat (192) @(posedge core_clk_i);
      rx_char(9'h093, 16'h0600, 1'b0);
      rd(`ASI_OFS_DATA, 16'h0093, 16'h01FF);
      rd(`ASI_OFS_CTRL, 16'h0000, 16'h0800);
    end
    wr(`ASI_OFS_CTRL, 16'h0620);
    rx_char(9'h03C, 16'h0600, 1'b0);
    cmp("oe", 16'h0001, line_oe_b_o);
    rd(`ASI_OFS_DATA, 16'h003C, 16'h01FF);
    // transmit: three queued writes, the third refused while both buffers hold data
    for (int i = 0; i < 3; i++) begin
      ctl = i == 0 ? 16'h1620 : i == 1 ? 16'h0603 : 16'h0601;
      wr(`ASI_OFS_CTRL, ctl);
      rd(`ASI_OFS_DATA, 16'h0000, 16'h0000);
      i_asi_remote.rx_bits = 9 + ctl[0];
      for (int j = 0; j < 3; j++) begin
        b = 9'($urandom);
        wr(`ASI_OFS_DATA, {7'h00, b});
        if (j < 2) fq.push_back(frame(b, 1'b0, ctl[0], ctl[1], 1'b0));
        repeat (4) @(posedge core_clk_i);
      end
      if (i > 0) rx_char(9'h069, ctl, 1'b0);
      if (i > 0) rd(`ASI_OFS_DATA, 16'h0069, 16'h01FF);
      repeat (420) @(posedge core_clk_i);
    end
    wr(`ASI_OFS_CTRL, 16'h0610);
    // stale receive flag from the duplex test would raise the interrupt at once
    rd(`ASI_OFS_STAT, 16'h0004, 16'h0004);
    wr(`ASI_OFS_MASK, 16'h0004);
    wr(`ASI_OFS_DATA, 16'h00E7);
    wait_irq(1'b1);
    rd(`ASI_OFS_DATA, 16'h00E7, 16'h01FF);
    // inverted echo on one wire: both inversions cancel, so the character comes back
    quiet <= 1'b1;
    wr(`ASI_OFS_CTRL, 16'h16E0);
    rd(`ASI_OFS_STAT, 16'h0004, 16'h0004);
    // let the false start from the idle level flip be rejected first
    repeat (20) @(posedge core_clk_i);
    wr(`ASI_OFS_DATA, 16'h005A);
    wait_irq(1'b1);
    rd(`ASI_OFS_STAT, 16'h0005, 16'h0005);
    rd(`ASI_OFS_DATA, 16'h005A, 16'h01FF);
    wr(`ASI_OFS_CTRL, 16'h0040);
    repeat (3) @(posedge core_clk_i);
    cmp("line", 16'h0000, line_o);
    cmp("frames left", 16'h0000, 16'(fq.size()));
    report_and_stop();
  end
endmodule
bind asi_core asi_core_sva i_asi_core_sva (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .rx_i(rx_i), .line_i(line_i), .line_o(line_o), .line_oe_b_o(line_oe_b_o), .irq_o(irq_o));
